// ===== common/mgmt_pkg.sv
`default_nettype none
package mgmt_pkg;
  // ==========================================================================
  // data and address
  // ==========================================================================
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned ADDR_BASE_W = 10;
  localparam int unsigned LANES_DEF   = 4;

  // ==========================================================================
  // soft control/status space layout (word index in low address bits)
  // ==========================================================================
  localparam int unsigned CS_IDX_W     = 3;
  localparam logic [2:0]  CS_RESET     = 3'h0;
  localparam logic [2:0]  CS_LOOPBACK  = 3'h1;
  localparam logic [2:0]  CS_STATUS    = 3'h2;
  localparam int unsigned RST_TX_BIT   = 0;
  localparam int unsigned RST_RX_BIT   = 1;

  // ==========================================================================
  // reset sequencer and reconfiguration space timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned RST_HOLD_NS   = 1000;
  localparam int unsigned RST_HOLD_CYC  =
    (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RECFG_LAT     = 2;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_RELEASE,
    SEQ_READY
  } seq_state_e;
endpackage : mgmt_pkg
`default_nettype wire

// ===== common/recfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface recfg_if #(parameter int unsigned AW = 12);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [31:0]   wdata;
  logic          ack;
  logic [31:0]   rdata;
  modport port (output req, output wr, output addr, output wdata,
                input ack, input rdata);
  modport space (input req, input wr, input addr, input wdata,
                 output ack, output rdata);
endinterface : recfg_if
`default_nettype wire

// ===== rtl/phy_mgmt_csr_port.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// RQ1: management clock runs the port, reconfiguration space and reset sequencer
// RQ2: reset high holds link layer, pll and phy in reset, level sensitive
// RQ3: address width is ten plus log2 of lane count
// RQ4: address msb one routes access to reconfiguration space
// RQ5: address msb zero routes access to soft reset/loopback space
// RQ6: master writes with write strobe and 32-bit word same cycle
// RQ7: master reads with read strobe; device returns 32-bit read word
// RQ8: stall output high while port cannot yet accept the request
// RQ9: reconfiguration-busy input is tied low by the integrator and ignored
// RQ10: one serial transmit and one receive line per lane
// RQ11: integrator ties link master reset to the global reset
// RQ12: master holds request stable while stall high; done when stall low
module phy_mgmt_csr_port
  import mgmt_pkg::*;
#(
  parameter int unsigned LANES = LANES_DEF,
  parameter int unsigned AW    = ADDR_BASE_W + $clog2(LANES)
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [AW-1:0]     management_address,
  input  wire logic              management_write,
  input  wire logic              management_read,
  input  wire logic [WORD_W-1:0] management_write_word,
  output var  logic [WORD_W-1:0] management_read_word,
  output var  logic              management_stall,
  input  wire logic              reconfig_busy,
  output var  logic              core_reset,
  output var  logic              phy_reset,
  output var  logic [LANES-1:0]  tx_serial_data,
  input  wire logic [LANES-1:0]  rx_serial_data,
  output var  logic [LANES-1:0]  loopback
);
  // ==========================================================================
  // declarations
  // ==========================================================================
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RECFG,
    BUS_DONE
  } bus_state_e;

  localparam int unsigned CW = $clog2(RST_HOLD_CYC + 1);

  recfg_if #(.AW(AW)) rbus ();

  bus_state_e        bus_state;
  bus_state_e        next_bus_state;
  seq_state_e        seq_state;
  seq_state_e        next_seq_state;
  logic [CW-1:0]     seq_cnt;
  logic [CW-1:0]     next_seq_cnt;
  logic [1:0]        soft_rst;
  logic [1:0]        next_soft_rst;
  logic [LANES-1:0]  next_loopback;
  logic [WORD_W-1:0] next_read_word;
  logic              next_stall;
  logic              next_core_reset;
  logic              next_phy_reset;
  logic [LANES-1:0]  next_tx;
  logic [LANES-1:0]  rx_q;
  logic              req;
  logic              to_recfg;
  logic [CS_IDX_W-1:0] cs_idx;
  logic              unused;

  assign req      = management_read | management_write;
  assign to_recfg = management_address[AW-1];                      // [RQ4]
  assign cs_idx   = management_address[CS_IDX_W-1:0];
  assign unused   = reconfig_busy;                                  // [RQ9]

  assign rbus.req   = (bus_state == BUS_RECFG);
  assign rbus.wr    = management_write;
  assign rbus.addr  = management_address;
  assign rbus.wdata = management_write_word;

  recfg_space #(.AW(AW)) u_recfg (
    .clk (clk),
    .rst (rst),
    .bus (rbus.space)
  );

  // ==========================================================================
  // management bus
  // ==========================================================================
  always_comb begin
    next_bus_state = bus_state;
    next_stall     = 1'b1;
    next_read_word = management_read_word;
    next_soft_rst  = soft_rst;
    next_loopback  = loopback;
    case (bus_state)
      BUS_IDLE: begin
        if (req && to_recfg) begin                                 // [RQ4]
          next_bus_state = BUS_RECFG;
        end else if (req) begin                                    // [RQ5]
          next_bus_state = BUS_DONE;
          next_stall     = 1'b0;
          if (management_write) begin                              // [RQ6]
            case (cs_idx)
              CS_RESET:    next_soft_rst =
                management_write_word[RST_RX_BIT:RST_TX_BIT];
              CS_LOOPBACK: next_loopback = management_write_word[LANES-1:0];
              default:     next_soft_rst = soft_rst;
            endcase
          end else begin
            case (cs_idx)                                          // [RQ7]
              CS_RESET:    next_read_word = WORD_W'(soft_rst);
              CS_LOOPBACK: next_read_word = WORD_W'(loopback);
              CS_STATUS:   next_read_word = WORD_W'(seq_state);
              default:     next_read_word = '0;
            endcase
          end
        end
      end
      BUS_RECFG: begin
        if (rbus.ack) begin
          next_bus_state = BUS_DONE;
          next_stall     = 1'b0;
          if (management_read) begin
            next_read_word = rbus.rdata;                           // [RQ7]
          end
        end
      end
      BUS_DONE: begin
        next_bus_state = BUS_IDLE;
      end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin                                   // [RQ1]
    if (rst) begin
      bus_state            <= BUS_IDLE;
      management_stall     <= 1'b1;                                // [RQ8]
      management_read_word <= '0;
      soft_rst             <= 2'h0;
      loopback             <= '0;
    end else begin
      bus_state            <= next_bus_state;
      management_stall     <= next_stall;                          // [RQ8]
      management_read_word <= next_read_word;
      soft_rst             <= next_soft_rst;
      loopback             <= next_loopback;
    end
  end

  // ==========================================================================
  // reset sequencer
  // ==========================================================================
  always_comb begin
    next_seq_state  = seq_state;
    next_seq_cnt    = seq_cnt;
    next_core_reset = 1'b1;
    next_phy_reset  = 1'b1;
    case (seq_state)
      SEQ_HOLD: begin
        next_seq_cnt = CW'(seq_cnt + 1'b1);
        if (seq_cnt == CW'(RST_HOLD_CYC - 1)) begin
          next_seq_state = SEQ_RELEASE;
          next_seq_cnt   = '0;
          next_phy_reset = soft_rst[RST_TX_BIT];
        end
      end
      SEQ_RELEASE: begin
        next_phy_reset  = soft_rst[RST_TX_BIT];
        next_seq_state  = SEQ_READY;
        next_core_reset = soft_rst[RST_RX_BIT];
      end
      SEQ_READY: begin
        next_phy_reset  = soft_rst[RST_TX_BIT];
        next_core_reset = soft_rst[RST_RX_BIT];
      end
      default: next_seq_state = SEQ_HOLD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin                                                 // [RQ2]
      seq_state  <= SEQ_HOLD;
      seq_cnt    <= '0;
      core_reset <= 1'b1;
      phy_reset  <= 1'b1;
    end else begin
      seq_state  <= next_seq_state;
      seq_cnt    <= next_seq_cnt;
      core_reset <= next_core_reset;
      phy_reset  <= next_phy_reset;
    end
  end

  // ==========================================================================
  // serial lanes: idle low under reset, loopback echoes receive line
  // ==========================================================================
  always_comb begin
    next_tx = '0;
    for (int i = 0; i < LANES; i++) begin                          // [RQ10]
      next_tx[i] = loopback[i] & rx_q[i] & ~phy_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_q           <= '0;
      tx_serial_data <= '0;
    end else begin
      rx_q           <= rx_serial_data;
      tx_serial_data <= next_tx;
    end
  end
endmodule : phy_mgmt_csr_port
`default_nettype wire

// ===== rtl/recfg_space.sv
`timescale 1ns/100ps
`default_nettype none
// reconfiguration space: word store answering after a fixed latency
module recfg_space
  import mgmt_pkg::*;
#(
  parameter int unsigned AW      = 12,
  parameter int unsigned DEPTH_W = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  recfg_if.space    bus
);
  logic [WORD_W-1:0] mem      [2**DEPTH_W];
  logic [WORD_W-1:0] next_mem [2**DEPTH_W];
  logic [1:0]        cnt;
  logic [1:0]        next_cnt;
  logic [WORD_W-1:0] rdata;
  logic [WORD_W-1:0] next_rdata;
  logic              ack;
  logic              next_ack;
  logic [DEPTH_W-1:0] idx;

  assign idx       = bus.addr[DEPTH_W-1:0];
  assign bus.ack   = ack;
  assign bus.rdata = rdata;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    next_mem   = mem;
    next_cnt   = cnt;
    next_ack   = 1'b0;
    next_rdata = rdata;
    if (bus.req && !ack) begin
      if (cnt == 2'(RECFG_LAT - 1)) begin
        next_cnt = 2'h0;
        next_ack = 1'b1;
        if (bus.wr) begin
          next_mem[idx] = bus.wdata;
        end else begin
          next_rdata = mem[idx];
        end
      end else begin
        next_cnt = 2'(cnt + 2'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 2**DEPTH_W; i++) begin
        mem[i] <= '0;
      end
      cnt   <= 2'h0;
      ack   <= 1'b0;
      rdata <= '0;
    end else begin
      mem   <= next_mem;
      cnt   <= next_cnt;
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end
endmodule : recfg_space
`default_nettype wire

// ===== tb/mgmt_master.sv
`timescale 1ns/100ps
`default_nettype none
module mgmt_master
  import mgmt_pkg::*;
#(
  parameter int unsigned AW = 12
) (
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic [WORD_W-1:0] rword,
  output var  logic [AW-1:0]     addr,
  output var  logic              wr,
  output var  logic              rd,
  output var  logic [WORD_W-1:0] wword
);
  // ========
  initial begin
    addr = '0;
    wr = 1'b0;
    rd = 1'b0;
    wword = '0;
  end
  task automatic access(input logic w, input logic [AW-1:0] a,
                        input logic [WORD_W-1:0] d,
                        output logic [WORD_W-1:0] q, output logic ok);
    q = '0;
    ok = 1'b0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wword <= d;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      if (stall === 1'b0) begin
        ok = 1'b1;
        q = rword;
      end
    end
    // released bus shows the inverse, not the last value
    addr <= ~a;
    wr <= 1'b0;
    rd <= 1'b0;
    wword <= ~d;
  endtask
endmodule // mgmt_master
`default_nettype wire

// ===== tb/phy_mgmt_csr_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_csr_port_checker
  import mgmt_pkg::*;
#(
  parameter int unsigned LANES = 4,
  parameter int unsigned AW    = 12
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [AW-1:0]     management_address,
  input wire logic              management_write,
  input wire logic              management_read,
  input wire logic [WORD_W-1:0] management_read_word,
  input wire logic              management_stall,
  input wire logic              core_reset,
  input wire logic              phy_reset,
  input wire logic [LANES-1:0]  tx_serial_data,
  input wire logic [LANES-1:0]  loopback
);
  // ========
  // cycles since reset release
  logic [7:0] since;
  logic [7:0] next_since;
  logic       req;
  assign req = management_read | management_write;
  always_comb begin
    next_since = (since == 8'hff) ? since : since + 8'h01;
  end
  always_ff @(posedge clk) begin
    since <= rst ? 8'h00 : next_since;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_state_a: assert property (disable iff (1'b0) rst |=>
    management_stall && core_reset && phy_reset && loopback == '0
    && tx_serial_data == '0 && management_read_word == '0)
    else $error("outputs not at reset values");
  seq_hold_a: assert property (since < RST_HOLD_CYC |-> core_reset && phy_reset)
    else $error("reset released too early");
  stall_pulse_a: assert property (!management_stall |=> management_stall)
    else $error("stall low longer than one cycle");
  answer_cause_a: assert property (!management_stall |-> $past(req))
    else $error("answer without request");
  soft_latency_a: assert property ($rose(req) &&
    !management_address[AW-1] |=> !management_stall)
    else $error("soft space answer late");
  recfg_latency_a: assert property ($rose(req) &&
    management_address[AW-1] |=> management_stall ##1 management_stall
    ##1 management_stall ##1 !management_stall)
    else $error("reconfig answer timing wrong");
  read_hold_a: assert property ($changed(management_read_word) |->
    !management_stall && management_read) else $error("read word moved");
  loop_off_a: assert property (loopback == '0 && $past(loopback) == '0
    |-> tx_serial_data == '0) else $error("tx active without loopback");
endmodule // phy_mgmt_csr_port_checker
`default_nettype wire

// ===== tb/phy_mgmt_csr_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_csr_port_tb_top;
  import mgmt_pkg::*;
  localparam int unsigned AW = 12;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] addr;
  logic        wr, rd, stall, core_rst, phy_rst;
  logic [31:0] wword, rword, seed = 32'h7;
  logic [31:0] mem [16];
  logic [3:0]  tx, rx = 4'h0, lb;
  int          n_fail = 0, checks = 0, cyc = 0;
  always #10 clk = ~clk;
  mgmt_master #(.AW(AW)) m (.clk(clk), .stall(stall), .rword(rword),
    .addr(addr), .wr(wr), .rd(rd), .wword(wword));
  phy_mgmt_csr_port uut (.clk(clk), .rst(rst), .management_address(addr),
    .management_write(wr), .management_read(rd),
    .management_write_word(wword), .management_read_word(rword),
    .management_stall(stall), .reconfig_busy(1'b0),
    .core_reset(core_rst), .phy_reset(phy_rst), .tx_serial_data(tx),
    .rx_serial_data(rx), .loopback(lb));
  // ========
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    m.access(w, a, d, q, ok);
    chk({31'h0, ok}, 32'h1);
    if (!w) chk(q, exp);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 chk({21'h0, stall, core_rst, phy_rst, lb, tx}, 32'h700);
    chk(rword, 32'h0);
    xfer(1'b0, 12'h002, 32'h0, 32'h0);
    repeat (RST_HOLD_CYC + 5) @(posedge clk);
    #1 chk({30'h0, core_rst, phy_rst}, 32'h0);
    xfer(1'b0, 12'h00a, 32'h0, 32'h2);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      mem[i] = seed;
      xfer(1'b1, {8'h80, i[3:0]}, seed, 32'h0);
    end
    xfer(1'b1, 12'h000, 32'h3, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk({30'h0, core_rst, phy_rst}, 32'h3);
    xfer(1'b0, 12'h000, 32'h0, 32'h3);
    xfer(1'b1, 12'h000, 32'h0, 32'h0);
    seed = lfsr(seed);
    rx <= seed[7:4];
    xfer(1'b1, 12'h001, seed, 32'h0);
    repeat (4) @(posedge clk);
    #1 chk({28'h0, tx}, {28'h0, seed[3:0] & seed[7:4]});
    xfer(1'b0, 12'h001, 32'h0, {28'h0, seed[3:0]});
    xfer(1'b1, 12'h005, seed, 32'h0);
    xfer(1'b0, 12'h005, 32'h0, 32'h0);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, {8'h80, i[3:0]}, 32'h0, mem[i]);
    end
    // mid-run reset held three cycles must clear soft space and reassert resets
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk({21'h0, stall, core_rst, phy_rst, lb, tx}, 32'h700);
    chk(rword, 32'h0);
    xfer(1'b0, 12'h001, 32'h0, 32'h0);
    xfer(1'b0, 12'h002, 32'h0, 32'h0);
    wrap_up();
  end
endmodule // phy_mgmt_csr_port_tb_top
bind phy_mgmt_csr_port phy_mgmt_csr_port_checker #(.LANES(LANES), .AW(AW))
  chk_i (.clk(clk), .rst(rst), .management_address(management_address),
    .management_write(management_write), .management_read(management_read),
    .management_read_word(management_read_word),
    .management_stall(management_stall), .core_reset(core_reset),
    .phy_reset(phy_reset), .tx_serial_data(tx_serial_data),
    .loopback(loopback));
`default_nettype wire
